// ### pin_change_pkg.sv
// Package with register map, field layouts and reset values for the pin change edge detector
package pin_change_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_PORTA_RISE  = 12'h000;
    localparam logic [11:0] OFF_PORTA_FALL  = 12'h004;
    localparam logic [11:0] OFF_PORTA_FLAGS = 12'h008;
    localparam logic [11:0] OFF_PORTB_RISE  = 12'h00c;
    localparam logic [11:0] OFF_PORTB_FALL  = 12'h010;
    localparam logic [11:0] OFF_PORTB_FLAGS = 12'h014;
    localparam logic [11:0] OFF_IRQ_CTRL    = 12'h018;

    // ------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PORTA_MASK    = 8'h3f;
    localparam logic [7:0] PORTB_MASK    = 8'hf0;
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam int         CTRL_IE_BIT   = 0;
    localparam int         CTRL_SUM_BIT  = 1;
    localparam int         CTRL_WAKE_BIT = 2;
    localparam logic [7:0] CTRL_WR_MASK  = 8'h01;
    localparam int         SYNC_STAGES   = 3;

    // Per-port enable and flag state
    typedef struct packed {
        logic [7:0] rise;
        logic [7:0] fall;
        logic [7:0] flags;
    } port_regs_s;

endpackage

// ### pin_change_edge_detector.sv
// Pin change edge detector for port A pins 5..0 and port B pins 7..4, APB slave
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Function
// [RQ1] Falling enable per port A pin 5..0
// [RQ2] Enabled falling edge sets flag and summary
// [RQ3] Disabled polarity never sets a flag
// [RQ4] Enabled rising edge sets port A flag
// [RQ5] Enabled falling edge sets port A flag
// [RQ6] Flags set by hardware, cleared writing zero
// [RQ7] Port B rising enables at bits 7..4
// [RQ8] Port B falling enables at bits 7..4
// [RQ9] Port B flag set on enabled edge
// [RQ10] Unimplemented bits read zero, ignore writes
// [RQ11] All enables and flags reset to zero
// [RQ12] Summary flag is OR of flags
// [RQ13] Detection runs regardless of master enable
// [RQ14] Edge during flag write keeps flag set
// [RQ15] Master enable lets edges request wake-up
// [RQ16] Edges found by comparing synced samples
module pin_change_edge_detector (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  port_a_pin,
    input  wire logic [7:0]  port_b_pin,
    output logic             change_irq_summary_flag,
    output logic             change_irq_request
);
    import pin_change_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_STAGES-1:0] sync_a_q [8];
    logic [SYNC_STAGES-1:0] sync_b_q [8];
    logic [7:0]             prev_a_q;
    logic [7:0]             prev_b_q;
    logic [7:0]             cur_a;
    logic [7:0]             cur_b;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_a_q[gi] <= '0;
                    sync_b_q[gi] <= '0;
                end else begin
                    sync_a_q[gi] <= {sync_a_q[gi][SYNC_STAGES-2:0], port_a_pin[gi]};
                    sync_b_q[gi] <= {sync_b_q[gi][SYNC_STAGES-2:0], port_b_pin[gi]};
                end
            end
            // Change counts only once stages two and three agree
            assign cur_a[gi] = (sync_a_q[gi][1] == sync_a_q[gi][2]) ? sync_a_q[gi][2] : prev_a_q[gi];
            assign cur_b[gi] = (sync_b_q[gi][1] == sync_b_q[gi][2]) ? sync_b_q[gi][2] : prev_b_q[gi];
        end
    endgenerate

    // Previous sample starts at zero; a pin high at reset release
    // therefore reports one rising edge if enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_a_q <= '0;
            prev_b_q <= '0;
        end else begin
            prev_a_q <= cur_a;
            prev_b_q <= cur_b;
        end
    end

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    port_regs_s pa_q, pa_d;
    port_regs_s pb_q, pb_d;
    logic       ie_q, ie_d;
    logic [7:0] set_a;
    logic [7:0] set_b;

    // Single-cycle set pulses, gated by each polarity's enable
    assign set_a = ((cur_a & ~prev_a_q & pa_q.rise)                      // [RQ16] [RQ4] [RQ3]
                 | (~cur_a & prev_a_q & pa_q.fall)) & PORTA_MASK;        // [RQ5] [RQ2] [RQ1]
    assign set_b = ((cur_b & ~prev_b_q & pb_q.rise)                      // [RQ9] [RQ3]
                 | (~cur_b & prev_b_q & pb_q.fall)) & PORTB_MASK;        // [RQ9]

    // ------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------
    logic        wr_en;
    logic        rd_en;
    logic [31:0] prdata_d;
    logic        pslverr_d;
    logic        sum_q, sum_d;
    logic        irq_q, irq_d;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == OFF_PORTA_RISE) || (a == OFF_PORTA_FALL) || (a == OFF_PORTA_FLAGS)
              || (a == OFF_PORTB_RISE) || (a == OFF_PORTB_FALL) || (a == OFF_PORTB_FLAGS)
              || (a == OFF_IRQ_CTRL);
    endfunction

    // Zero-wait slave: the access phase completes in its first cycle
    assign wr_en = psel && penable && pwrite && pstrb[0] && mapped(paddr);
    assign rd_en = psel && penable && !pwrite;

    always_comb begin
        pa_d      = pa_q;
        pb_d      = pb_q;
        ie_d      = ie_q;
        prdata_d  = prdata;
        pslverr_d = 1'b0;
        if (wr_en) begin
            if (paddr == OFF_PORTA_RISE) begin
                pa_d.rise = pwdata[7:0] & PORTA_MASK;                    // [RQ10]
            end else if (paddr == OFF_PORTA_FALL) begin
                pa_d.fall = pwdata[7:0] & PORTA_MASK;                    // [RQ1] [RQ10]
            end else if (paddr == OFF_PORTA_FLAGS) begin
                pa_d.flags = pa_q.flags & pwdata[7:0];                   // [RQ6]
            end else if (paddr == OFF_PORTB_RISE) begin
                pb_d.rise = pwdata[7:0] & PORTB_MASK;                    // [RQ7] [RQ10]
            end else if (paddr == OFF_PORTB_FALL) begin
                pb_d.fall = pwdata[7:0] & PORTB_MASK;                    // [RQ8] [RQ10]
            end else if (paddr == OFF_PORTB_FLAGS) begin
                pb_d.flags = pb_q.flags & pwdata[7:0];                   // [RQ6]
            end else if (paddr == OFF_IRQ_CTRL) begin
                ie_d = pwdata[CTRL_IE_BIT];
            end
        end
        // Software can only clear; hardware set wins over a clear
        pa_d.flags = (pa_d.flags | set_a) & PORTA_MASK;                  // [RQ14] [RQ6] [RQ13]
        pb_d.flags = (pb_d.flags | set_b) & PORTB_MASK;                  // [RQ14] [RQ6] [RQ13]
        if (psel && penable) begin
            pslverr_d = !mapped(paddr);
        end
        if (rd_en) begin
            prdata_d = '0;
            if (paddr == OFF_PORTA_RISE) begin
                prdata_d[7:0] = pa_q.rise;
            end else if (paddr == OFF_PORTA_FALL) begin
                prdata_d[7:0] = pa_q.fall;
            end else if (paddr == OFF_PORTA_FLAGS) begin
                prdata_d[7:0] = pa_q.flags;
            end else if (paddr == OFF_PORTB_RISE) begin
                prdata_d[7:0] = pb_q.rise;
            end else if (paddr == OFF_PORTB_FALL) begin
                prdata_d[7:0] = pb_q.fall;
            end else if (paddr == OFF_PORTB_FLAGS) begin
                prdata_d[7:0] = pb_q.flags;
            end else if (paddr == OFF_IRQ_CTRL) begin
                prdata_d[CTRL_IE_BIT]   = ie_q;
                prdata_d[CTRL_SUM_BIT]  = sum_q;
                prdata_d[CTRL_WAKE_BIT] = irq_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Summary flag and interrupt / wake request
    // ------------------------------------------------------------
    always_comb begin
        sum_d = |{pa_d.flags, pb_d.flags};                               // [RQ12] [RQ2]
        irq_d = sum_d && ie_d;                                           // [RQ15] [RQ13]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_q    <= '{rise: REG_RESET, fall: REG_RESET, flags: REG_RESET}; // [RQ11]
            pb_q    <= '{rise: REG_RESET, fall: REG_RESET, flags: REG_RESET}; // [RQ11]
            ie_q    <= 1'b0;
            sum_q   <= 1'b0;
            irq_q   <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
            pready  <= 1'b1;
        end else begin
            pa_q    <= pa_d;
            pb_q    <= pb_d;
            ie_q    <= ie_d;
            sum_q   <= sum_d;
            irq_q   <= irq_d;
            prdata  <= prdata_d;
            pslverr <= pslverr_d;
            pready  <= 1'b1;
        end
    end

    always_comb begin
        change_irq_summary_flag = sum_q;
        change_irq_request      = irq_q;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_flag_set_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (set_a != 8'h00) |=> ((pa_q.flags & $past(set_a)) == $past(set_a)))  // [RQ14]
        else $error("Port A flag not set by edge");
    a_b_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        (set_b != 8'h00) |=> ((pb_q.flags & $past(set_b)) == $past(set_b)))  // [RQ9]
        else $error("Port B flag not set by edge");
    a_no_hw_clear: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_en |=> ((pa_q.flags & $past(pa_q.flags)) == $past(pa_q.flags))) // [RQ6]
        else $error("Flag dropped without a write");
    a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ((pa_q.rise | pa_q.fall | pa_q.flags) & ~PORTA_MASK) == 8'h00
        && ((pb_q.rise | pb_q.fall | pb_q.flags) & ~PORTB_MASK) == 8'h00) // [RQ10]
        else $error("Unimplemented bit set");
    a_summary_or: assert property (@(posedge pclk) disable iff (!presetn)
        change_irq_summary_flag == |{pa_q.flags, pb_q.flags})             // [RQ12]
        else $error("Summary flag mismatch");
    a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
        change_irq_request == (change_irq_summary_flag && ie_q))           // [RQ15]
        else $error("Request not gated by master enable");
    a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (cur_a & ~prev_a_q & ~pa_q.rise & ~pa_q.fall) != 8'h00 |-> (set_a & (cur_a & ~prev_a_q & ~pa_q.rise)) == 8'h00) // [RQ3]
        else $error("Disabled edge reported");
    a_fall_detect: assert property (@(posedge pclk) disable iff (!presetn)
        (($past(cur_a) & ~cur_a & pa_q.fall & PORTA_MASK) != 8'h00 && $stable(pa_q.fall))
        |-> (set_a != 8'h00))                                              // [RQ5]
        else $error("Enabled falling edge missed");
    a_reset_zero: assert property (@(posedge pclk)
        $rose(presetn) |-> (pa_q == '0 && pb_q == '0))                     // [RQ11]
        else $error("Registers not zero after reset");

    // ------------------------------------------------------------
    // Register write and detector checks
    // ------------------------------------------------------------
    // These tie each next-state rule to the registered result, so a broken
    // merge of software clear and hardware set shows up at once

    a_rise_detect_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
        ((cur_a & ~prev_a_q & pa_q.rise & PORTA_MASK) != 8'h00) |-> (set_a != 8'h00))
        else $error("Enabled port A rising edge missed");

    a_rise_detect_b: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
        ((cur_b & ~prev_b_q & pb_q.rise & PORTB_MASK) != 8'h00) |-> (set_b != 8'h00))
        else $error("Enabled port B rising edge missed");

    a_fall_detect_b: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
        ((~cur_b & prev_b_q & pb_q.fall & PORTB_MASK) != 8'h00) |-> (set_b != 8'h00))
        else $error("Enabled port B falling edge missed");

    a_a_needs_enable: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
        (set_a & ~(pa_q.rise | pa_q.fall)) == 8'h00)
        else $error("Port A set without any enable");

    a_b_needs_enable: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
        (set_b & ~(pb_q.rise | pb_q.fall)) == 8'h00)
        else $error("Port B set without any enable");

    a_b_no_hw_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
        !wr_en |=> ((pb_q.flags & $past(pb_q.flags)) == $past(pb_q.flags)))
        else $error("Port B flag dropped without a write");

    // A change must stand two cycles in the chain, so one pin never sets twice in a row
    a_single_pulse: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
        (set_a != 8'h00) |=> ((set_a & $past(set_a)) == 8'h00))
        else $error("Port A set pulse longer than one cycle");

    a_prev_tracks_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
        prev_a_q == $past(cur_a))
        else $error("Port A previous sample lost");

    a_prev_tracks_b: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
        prev_b_q == $past(cur_b))
        else $error("Port B previous sample lost");

    a_a_flag_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
        (wr_en && paddr == OFF_PORTA_FLAGS) |=> pa_q.flags ==
        ((($past(pa_q.flags) & $past(pwdata[7:0])) | $past(set_a)) & PORTA_MASK))
        else $error("Port A flag write merge wrong");

    a_b_flag_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
        (wr_en && paddr == OFF_PORTB_FLAGS) |=> pb_q.flags ==
        ((($past(pb_q.flags) & $past(pwdata[7:0])) | $past(set_b)) & PORTB_MASK))
        else $error("Port B flag write merge wrong");

    a_a_rise_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
        (wr_en && paddr == OFF_PORTA_RISE) |=> pa_q.rise == ($past(pwdata[7:0]) & PORTA_MASK))
        else $error("Port A rising enable write wrong");

    a_a_fall_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
        (wr_en && paddr == OFF_PORTA_FALL) |=> pa_q.fall == ($past(pwdata[7:0]) & PORTA_MASK))
        else $error("Port A falling enable write wrong");

    a_b_rise_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
        (wr_en && paddr == OFF_PORTB_RISE) |=> pb_q.rise == ($past(pwdata[7:0]) & PORTB_MASK))
        else $error("Port B rising enable write wrong");

    a_b_fall_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
        (wr_en && paddr == OFF_PORTB_FALL) |=> pb_q.fall == ($past(pwdata[7:0]) & PORTB_MASK))
        else $error("Port B falling enable write wrong");

    a_ie_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
        (wr_en && paddr == OFF_IRQ_CTRL) |=> ie_q == $past(pwdata[CTRL_IE_BIT]))
        else $error("Master enable write wrong");

    // Error is a one-cycle pulse, so a master must sample it in the following cycle
    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
        (psel && penable && !mapped(paddr)) |=> pslverr)
        else $error("Unmapped access without error");

    a_rdata_upper: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
        prdata[31:8] == 24'h000000)
        else $error("Read data upper bits not zero");

endmodule

// ### pin_source.sv
// Model of the outside signals that drive the two port pin groups
`timescale 1ns/1ps
module pin_source (
    input  wire logic       pclk,
    input  wire logic [7:0] a_level,
    input  wire logic [7:0] b_level,
    output logic      [7:0] port_a_pin,
    output logic      [7:0] port_b_pin
);
    // Levels move just after an edge; unused pins follow too, so they must not matter
    always @(posedge pclk) begin
        port_a_pin <= a_level;
        port_b_pin <= b_level;
    end
endmodule

// ### testbench.sv
// Self-checking testbench for the pin change edge detector
`timescale 1ns/1ps
module testbench;
    import pin_change_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sum_flag, irq_req, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  a_level, b_level, port_a_pin, port_b_pin;
    int          fails, checks;

    pin_change_edge_detector u_pin_change_edge_detector (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_a_pin(port_a_pin), .port_b_pin(port_b_pin),
        .change_irq_summary_flag(sum_flag), .change_irq_request(irq_req));
    pin_source u_pin_source (.pclk(pclk), .a_level(a_level), .b_level(b_level),
        .port_a_pin(port_a_pin), .port_b_pin(port_b_pin));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Request held until pready is sampled high; data and error are registered,
    // so both are taken mid-cycle after the completing edge, where they are settled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            results();
        end
        @(negedge pclk);
        rd  = prdata;
        err = pslverr;
        @(posedge pclk);
    endtask

    task automatic wait_sum();
        int n;
        for (n = 0; n < 20 && sum_flag !== 1'b1; n++) @(posedge pclk);
        if (n == 20) chk("summary wait", 1, 0);
        repeat (4) @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [11:0] offs[7] = '{OFF_PORTA_RISE, OFF_PORTA_FALL, OFF_PORTA_FLAGS, OFF_PORTB_RISE,
                                 OFF_PORTB_FALL, OFF_PORTB_FLAGS, OFF_IRQ_CTRL};
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 0);
            chk("reset value", 0, rd);
        end
        apb(1'b1, 12'h040, 32'hffffffff);
        apb(1'b0, 12'h040, 0);
        chk("unmapped read", 0, rd);
        chk("unmapped error", 1, err);
        $display("test reset done");
    endtask

    task automatic t_enables();
        logic [11:0] offs[6] = '{OFF_PORTA_RISE, OFF_PORTA_FALL, OFF_PORTB_RISE, OFF_PORTB_FALL,
                                 OFF_PORTA_FLAGS, OFF_PORTB_FLAGS};
        logic [7:0]  exp[6]  = '{PORTA_MASK, PORTA_MASK, PORTB_MASK, PORTB_MASK, 8'h00, 8'h00};
        foreach (offs[i]) begin
            apb(1'b1, offs[i], 32'h000000ff);
            apb(1'b0, offs[i], 0);
            chk("enable mask", {24'h0, exp[i]}, rd);
            apb(1'b1, offs[i], 0);
        end
        $display("test enables done");
    endtask

    task automatic t_porta();
        apb(1'b1, OFF_PORTA_RISE, 32'h01);
        apb(1'b1, OFF_PORTA_FALL, 32'h02);
        a_level <= 8'h03;
        wait_sum();
        apb(1'b0, OFF_PORTA_FLAGS, 0);
        chk("porta rise flags", 32'h01, rd);
        chk("request off", 0, irq_req);
        apb(1'b1, OFF_PORTA_FLAGS, 0);
        apb(1'b0, OFF_PORTA_FLAGS, 0);
        chk("porta cleared", 0, rd);
        chk("summary clear", 0, sum_flag);
        a_level <= 8'h00;
        wait_sum();
        apb(1'b1, OFF_PORTA_FLAGS, 32'hfe);
        apb(1'b0, OFF_PORTA_FLAGS, 0);
        chk("porta fall flags", 32'h02, rd);
        apb(1'b1, OFF_PORTA_FLAGS, 0);
        $display("test porta done");
    endtask

    task automatic t_portb();
        apb(1'b1, OFF_IRQ_CTRL, 32'h01);
        apb(1'b1, OFF_PORTB_RISE, 32'h90);
        apb(1'b1, OFF_PORTB_FALL, 32'h60);
        b_level <= 8'hff;
        wait_sum();
        chk("wake request", 1, irq_req);
        apb(1'b0, OFF_PORTB_FLAGS, 0);
        chk("portb rise flags", 32'h90, rd);
        apb(1'b1, OFF_PORTB_FLAGS, 0);
        b_level <= 8'h00;
        wait_sum();
        apb(1'b0, OFF_PORTB_FLAGS, 0);
        chk("portb fall flags", 32'h60, rd);
        apb(1'b1, OFF_PORTB_FLAGS, 0);
        apb(1'b1, OFF_IRQ_CTRL, 0);
        $display("test portb done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        #2ms;
        fails++;
        results();
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        pstrb = 4'hf; a_level = 8'h00; b_level = 8'h00; fails = 0; checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_enables();
        t_porta();
        t_portb();
        results();
    end
endmodule
